/* dv/hall_pwm_partner.sv */
// Behavioural Hall sensor set and raw PWM generator facing the commutation timer.
`timescale 1ns/1ps
`default_nettype none
module hall_pwm_partner
   import bldc_commutation_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Commands from the bench.
   input  wire logic       step_one,
   input  wire logic       step_two,
   // Sensor levels and raw channels.
   output var  hall_s      hall,
   output var  logic [5:0] pwm_raw
);
   // -----------------------------------------------------------------
   // Sensor rotation and raw channels
   // -----------------------------------------------------------------
   // A step changes one pin as a turning rotor does; two pins only on command.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hall    <= 3'b001;
         pwm_raw <= 6'h00;
      end else begin
         pwm_raw <= pwm_raw + 6'h01; // Changes every cycle so stale shaping shows.
         if (step_two)
            hall <= {hall.hall_input_a, ~hall.hall_input_b, ~hall.hall_input_c};
         else if (step_one)
            hall <= {hall.hall_input_b, hall.hall_input_c, ~hall.hall_input_a};
      end
   end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the commutation timer with its sensor and PWM partner.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bldc_commutation_pkg::*;
   localparam int PS = 4;
   logic        clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, strobe = 1'b0, st1 = 1'b0, st2 = 1'b0;
   logic [15:0] period = 16'h0003;
   sector_e     sector = SECTOR_0;
   hall_s       hall, levels;
   logic [5:0]  raw, raw_s, pwm_out;
   logic        trig, hw1, hw2, ovf, ch0, cap_v;
   logic [15:0] count, capture;
   sector_e     act_sec;
   pattern_s    act_pat, pat_s;
   int          fail_count = 0, total_checks = 0, trig_seen = 0;
   logic [23:0] exp_pat [8] = '{24'h080834, 24'h20201C, 24'h202013, 24'h020231,
                                24'h02020D, 24'h080807, 24'h0A0A05, 24'h00003F};

   // -----------------------------------------------------------------
   // Clock, partner and design
   // -----------------------------------------------------------------
   // Half period of 2.5 ns gives 200 MHz.
   always #2.5 clk = ~clk;
   hall_pwm_partner far_u (.clk(clk), .reset_n(reset_n), .step_one(st1), .step_two(st2),
                           .hall(hall), .pwm_raw(raw));
   bldc_commutation_timer #(.PRESCALE(PS)) dut_u (.CLK(clk), .RESET_N(reset_n),
      .HALL_XOR_COMBINE_SELECT(hsel), .COMMUTATION_PERIOD_VALUE(period),
      .HALL_INPUT_A(hall.hall_input_a), .HALL_INPUT_B(hall.hall_input_b),
      .HALL_INPUT_C(hall.hall_input_c), .NEXT_SECTOR(sector), .PATTERN_SYNC_STROBE(strobe),
      .PWM_RAW(raw), .PWM_OUT(pwm_out), .CYCLE_START_TRIGGER(trig), .PWM_HW_TRIGGER_ONE(hw1),
      .PWM_HW_TRIGGER_TWO(hw2), .OVERFLOW_EVENT(ovf), .CHANNEL_ZERO_OUT(ch0),
      .COMMUTATION_COUNT(count), .COMMUTATION_PERIOD_CAPTURE(capture), .CAPTURE_VALID(cap_v),
      .HALL_SECTOR_LEVELS(levels), .ACTIVE_SECTOR(act_sec), .ACTIVE_PATTERN(act_pat));

   // Keeps what the design sampled at each edge, and counts trigger pulses.
   always @(posedge clk) begin
      raw_s <= raw;
      pat_s <= act_pat;
      if (trig === 1'b1) trig_seen++;
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Shaped channels: override enables low byte, forced values high byte, mask to 0.
   function automatic logic [5:0] shape(input logic [5:0] r, input pattern_s p);
      logic [5:0] en;
      en = p.software_output_override[5:0];
      return ((r & ~en) | (p.software_output_override[13:8] & en)) & ~p.output_mask_value[5:0];
   endfunction
   task automatic wait_pulse(input bit cap, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (((cap ? cap_v : ovf) !== 1'b1) && n < 300);
      if (n >= 300) check(1'b0, 1'b1);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   // Sensorless schedule, patterns, Hall capture, then the software sync strobe.
   initial begin
      int n;
      repeat (3) @(posedge clk);
      check(act_pat, exp_pat[7]);
      @(negedge clk) reset_n = 1'b1;
      for (int s = 0; s < 8; s++) begin
         period = (s < 4) ? 16'h0003 : 16'h0001;
         sector = sector_e'(s);
         wait_pulse(1'b0, n);
         if (s > 0) check(n, period * PS);
         check({trig, hw1, ch0, count}, {3'b111, 16'h0000});
         @(negedge clk);
         check({act_sec, act_pat}, {s[2:0], exp_pat[s]});
         repeat (PS - 2) begin
            @(negedge clk);
            check(pwm_out, shape(raw_s, pat_s));
         end
         check(ch0, 1'b1);
         @(negedge clk);
         check(ch0, 1'b0);
      end
      hsel = 1'b1;
      trig_seen = 0;
      repeat (40) @(negedge clk);
      check({trig_seen[7:0], count}, 24'h0);
      for (int i = 0; i < 7; i++) begin
         trig_seen = 0;
         pulse(st1);
         wait_pulse(1'b1, n);
         check({trig, hw1, levels}, {2'b11, hall});
         if (i > 1) check(capture >= 16'h000A && capture <= 16'h000C, 1'b1);
         repeat (40) @(negedge clk);
         check(trig_seen, 1);
      end
      trig_seen = 0;
      pulse(st2);
      repeat (20) @(negedge clk);
      check(trig_seen, 0);
      sector = SECTOR_ALIGN;
      pulse(strobe);
      check(hw2, 1'b1);
      @(negedge clk);
      check({act_sec, act_pat}, {SECTOR_ALIGN, exp_pat[6]});
      print_verdict();
   end

   // Cuts a hang short at 4000 cycles, well past the few hundred cycles the tests need.
   initial begin
      #20000;
      fail_count++;
      print_verdict();
   end
endmodule
`default_nettype wire

/* pkg/bldc_commutation_params.svh */
// Constants for the brushless commutation timer and its sector pattern buffer.
// What this block does
// - Sensorless counter schedules next commutation at the loaded period; new period moves it.
// - Counter overflow drives a cycle-start trigger pulse and an overflow event.
// - Channel zero pulses for exactly one counter tick per period, match fixed at one.
// - Cycle-start trigger drives hardware trigger one of the PWM generator.
// - Counter ticks at 625 kHz, an 80 MHz source divided by 128.
// - Hall mode combines the three Hall inputs by exclusive OR into one channel.
// - Every combined Hall edge is a commutation and raises the cycle-start trigger.
// - Each commutation loads the buffered override and mask pattern of the new sector.
// - Each Hall edge captures elapsed count as period and restarts the counter.
// - Rotor sector comes from the plain levels of the three Hall inputs.
// - Hall capture counter is 16 bits, maximum 65535 at 625000 Hz.
// - Fixed override and mask values for sectors zero to five, alignment and off.
// - Override forces selected channels to a level; mask forces them inactive.
// - A pattern sync strobe raises hardware trigger two and applies the buffered pattern.
`ifndef BLDC_COMMUTATION_PARAMS_SVH
`define BLDC_COMMUTATION_PARAMS_SVH

// -----------------------------------------------------------------
// Clock rates
// -----------------------------------------------------------------
`define CLK_HZ          200000000
`define SRC_CLK_HZ      80000000
`define SRC_PRESCALE    128
`define TICK_HZ         (`SRC_CLK_HZ / `SRC_PRESCALE)
`define PRESCALE_CYCLES (`CLK_HZ / `TICK_HZ)

// -----------------------------------------------------------------
// Counters
// -----------------------------------------------------------------
`define CNT_W           16
`define CNT_ZERO        16'h0000
`define CNT_STEP        16'h0001
`define HALL_CNT_MAX    16'hFFFF
`define CH0_MATCH       16'h0001

// -----------------------------------------------------------------
// Output pattern layout
// -----------------------------------------------------------------
`define PWM_CH          6
`define OVR_EN_LSB      0
`define OVR_VAL_LSB     8
`define MASK_INACTIVE   1'b0

// -----------------------------------------------------------------
// Sector patterns: override then mask
// -----------------------------------------------------------------
`define OVR_SECTOR0     16'h0808
`define MSK_SECTOR0     8'h34
`define OVR_SECTOR1     16'h2020
`define MSK_SECTOR1     8'h1C
`define OVR_SECTOR2     16'h2020
`define MSK_SECTOR2     8'h13
`define OVR_SECTOR3     16'h0202
`define MSK_SECTOR3     8'h31
`define OVR_SECTOR4     16'h0202
`define MSK_SECTOR4     8'h0D
`define OVR_SECTOR5     16'h0808
`define MSK_SECTOR5     8'h07
`define OVR_ALIGN       16'h0A0A
`define MSK_ALIGN       8'h05
`define OVR_OFF         16'h0000
`define MSK_OFF         8'h3F

`endif

/* pkg/bldc_commutation_pkg.sv */
// Types shared by the commutation timer and the sector pattern buffer.
package bldc_commutation_pkg;

   // -----------------------------------------------------------------
   // Sector codes
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      SECTOR_0     = 3'b000,
      SECTOR_1     = 3'b001,
      SECTOR_2     = 3'b010,
      SECTOR_3     = 3'b011,
      SECTOR_4     = 3'b100,
      SECTOR_5     = 3'b101,
      SECTOR_ALIGN = 3'b110,
      SECTOR_OFF   = 3'b111
   } sector_e;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic hall_input_a;
      logic hall_input_b;
      logic hall_input_c;
   } hall_s;

   typedef struct packed {
      logic [15:0] software_output_override;
      logic [7:0]  output_mask_value;
   } pattern_s;

endpackage

/* verilog/bldc_commutation_timer.sv */
// Commutation scheduler and Hall capture timer driving the PWM pattern triggers.
`timescale 1ns/1ps
`default_nettype none
`include "bldc_commutation_params.svh"

module bldc_commutation_timer
   import bldc_commutation_pkg::*;
#(
   parameter int PRESCALE = `PRESCALE_CYCLES
)(
   // Clock and reset.
   input  wire logic                CLK,
   input  wire logic                RESET_N,
   // Mode and scheduling from software.
   input  wire logic                HALL_XOR_COMBINE_SELECT,
   input  wire logic [`CNT_W-1:0]   COMMUTATION_PERIOD_VALUE,
   // Hall sensor pins.
   input  wire logic                HALL_INPUT_A,
   input  wire logic                HALL_INPUT_B,
   input  wire logic                HALL_INPUT_C,
   // Pattern buffer and software sync.
   input  wire sector_e             NEXT_SECTOR,
   input  wire logic                PATTERN_SYNC_STROBE,
   // PWM generator channels.
   input  wire logic [`PWM_CH-1:0]  PWM_RAW,
   output logic      [`PWM_CH-1:0]  PWM_OUT,
   // Triggers and events.
   output logic                     CYCLE_START_TRIGGER,
   output logic                     PWM_HW_TRIGGER_ONE,
   output logic                     PWM_HW_TRIGGER_TWO,
   output logic                     OVERFLOW_EVENT,
   output logic                     CHANNEL_ZERO_OUT,
   // Counter and capture state.
   output logic      [`CNT_W-1:0]   COMMUTATION_COUNT,
   output logic      [`CNT_W-1:0]   COMMUTATION_PERIOD_CAPTURE,
   output logic                     CAPTURE_VALID,
   output var  hall_s               HALL_SECTOR_LEVELS,
   output var  sector_e             ACTIVE_SECTOR,
   output var  pattern_s            ACTIVE_PATTERN
);

   localparam int PRESC_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
   localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESCALE - 1);

   // -----------------------------------------------------------------
   // Counter clock enable
   // -----------------------------------------------------------------
   logic [PRESC_W-1:0] presc_count;
   logic               tick;

   // Divides the clock down to the counter tick rate.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         presc_count <= '0;
         tick        <= 1'b0;
      end else if (presc_count == PRESC_LAST) begin
         presc_count <= '0;
         tick        <= 1'b1;
      end else begin
         presc_count <= presc_count + PRESC_W'(1);
         tick        <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Mode
   // -----------------------------------------------------------------
   logic hall_mode;

   // Sensorless scheduling runs only while Hall mode is deselected.
   assign hall_mode = HALL_XOR_COMBINE_SELECT;

   // -----------------------------------------------------------------
   // Sensorless commutation scheduler
   // -----------------------------------------------------------------
   logic              at_period;
   logic              sched_wrap;
   logic [`CNT_W-1:0] next_comm_count;

   // A period written below the running count wraps on the next tick.
   assign at_period  = COMMUTATION_COUNT >= COMMUTATION_PERIOD_VALUE;
   assign sched_wrap = !hall_mode && tick && at_period;

   // Next value of the up counter, held at zero in Hall mode.
   always_comb begin
      next_comm_count = COMMUTATION_COUNT;
      if (hall_mode)
         next_comm_count = `CNT_ZERO;
      else if (tick && at_period)
         next_comm_count = `CNT_ZERO;
      else if (tick)
         next_comm_count = COMMUTATION_COUNT + `CNT_STEP;
   end

   // Commutation counter register.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         COMMUTATION_COUNT <= `CNT_ZERO;
      else
         COMMUTATION_COUNT <= next_comm_count;
   end

   // Channel zero is high from the wrap until the count reaches its match.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         CHANNEL_ZERO_OUT <= 1'b0;
      else
         CHANNEL_ZERO_OUT <= !hall_mode && (next_comm_count < `CH0_MATCH);
   end

   // Overflow event towards software.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         OVERFLOW_EVENT <= 1'b0;
      else
         OVERFLOW_EVENT <= sched_wrap;
   end

   // -----------------------------------------------------------------
   // Hall input synchroniser
   // -----------------------------------------------------------------
   hall_s hall_meta;
   hall_s hall_sync;
   logic  combined_hall_channel;
   logic  combined_prev;
   logic  hall_edge;

   // Two flops per pin; only the second stage feeds any logic.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hall_meta <= '0;
         hall_sync <= '0;
      end else begin
         hall_meta <= '{HALL_INPUT_A, HALL_INPUT_B, HALL_INPUT_C};
         hall_sync <= hall_meta;
      end
   end

   // One combined channel from all three sensors.
   assign combined_hall_channel = hall_sync.hall_input_a
                                ^ hall_sync.hall_input_b
                                ^ hall_sync.hall_input_c;

   // Tracks the channel in both modes so a mode change gives no false edge.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         combined_prev <= 1'b0;
      else
         combined_prev <= combined_hall_channel;
   end

   assign hall_edge = hall_mode && (combined_hall_channel != combined_prev);

   // Sector levels read straight from the synchronised pins.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         HALL_SECTOR_LEVELS <= '0;
      else
         HALL_SECTOR_LEVELS <= hall_sync;
   end

   // -----------------------------------------------------------------
   // Hall capture counter
   // -----------------------------------------------------------------
   logic [`CNT_W-1:0] hall_count;

   // Free-running count of ticks since the last Hall edge.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         hall_count <= `CNT_ZERO;
      else if (!hall_mode || hall_edge)
         hall_count <= `CNT_ZERO;
      else if (tick && hall_count == `HALL_CNT_MAX)
         hall_count <= `CNT_ZERO;
      else if (tick)
         hall_count <= hall_count + `CNT_STEP;
   end

   // Elapsed time latched on each edge.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         COMMUTATION_PERIOD_CAPTURE <= `CNT_ZERO;
         CAPTURE_VALID              <= 1'b0;
      end else begin
         CAPTURE_VALID <= hall_edge;
         if (hall_edge)
            COMMUTATION_PERIOD_CAPTURE <= hall_count;
      end
   end

   // -----------------------------------------------------------------
   // Triggers to the PWM generator
   // -----------------------------------------------------------------

   // Cycle start comes from overflow or from a Hall edge by mode.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         CYCLE_START_TRIGGER <= 1'b0;
      else
         CYCLE_START_TRIGGER <= hall_mode ? hall_edge : sched_wrap;
   end

   // Hardware trigger one is the cycle start itself.
   assign PWM_HW_TRIGGER_ONE = CYCLE_START_TRIGGER;

   // Software sync strobe becomes hardware trigger two.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         PWM_HW_TRIGGER_TWO <= 1'b0;
      else
         PWM_HW_TRIGGER_TWO <= PATTERN_SYNC_STROBE;
   end

   // -----------------------------------------------------------------
   // Pattern buffer
   // -----------------------------------------------------------------
   sector_pattern_buffer u_pattern (
      .clk            (CLK),
      .reset_n        (RESET_N),
      .next_sector    (NEXT_SECTOR),
      .load_one       (PWM_HW_TRIGGER_ONE),
      .load_two       (PWM_HW_TRIGGER_TWO),
      .pwm_raw        (PWM_RAW),
      .active_sector  (ACTIVE_SECTOR),
      .active_pattern (ACTIVE_PATTERN),
      .pwm_out        (PWM_OUT)
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_sched_wrap;
      !hall_mode && tick && at_period;
   endsequence

   sequence s_wrap_result;
      COMMUTATION_COUNT == `CNT_ZERO && OVERFLOW_EVENT && CYCLE_START_TRIGGER;
   endsequence

   property p_overflow_wrap;
      @(posedge CLK) disable iff (!RESET_N)
      s_sched_wrap |=> s_wrap_result;
   endproperty
   a_overflow_wrap: assert property (p_overflow_wrap)
      else $error("Scheduler did not wrap with overflow and trigger.");

   property p_no_early_wrap;
      @(posedge CLK) disable iff (!RESET_N)
      (!hall_mode && !at_period) |=> !OVERFLOW_EVENT;
   endproperty
   a_no_early_wrap: assert property (p_no_early_wrap)
      else $error("Overflow before the period value was reached.");

   property p_trigger_pulse;
      @(posedge CLK) disable iff (!RESET_N)
      (CYCLE_START_TRIGGER && PRESCALE > 2) |=> !CYCLE_START_TRIGGER;
   endproperty
   a_trigger_pulse: assert property (p_trigger_pulse)
      else $error("Cycle-start trigger longer than one cycle.");

   // Reset release and leaving Hall mode start from a zero count, which is no wrap.
   property p_ch0_with_trigger;
      @(posedge CLK) disable iff (!RESET_N)
      (!hall_mode && $rose(CHANNEL_ZERO_OUT) && $past(COMMUTATION_COUNT) != `CNT_ZERO)
      |-> OVERFLOW_EVENT;
   endproperty
   a_ch0_with_trigger: assert property (p_ch0_with_trigger)
      else $error("Channel zero rose away from the wrap.");

   property p_ch0_one_tick;
      @(posedge CLK) disable iff (!RESET_N)
      (!hall_mode && CHANNEL_ZERO_OUT) |-> COMMUTATION_COUNT == `CNT_ZERO;
   endproperty
   a_ch0_one_tick: assert property (p_ch0_one_tick)
      else $error("Channel zero high past its match.");

   property p_tick_spacing;
      @(posedge CLK) disable iff (!RESET_N)
      (tick && PRESCALE > 2) |=> !tick [*2];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("Counter ticks closer than the prescaler allows.");

   sequence s_hall_edge;
      hall_mode && (combined_hall_channel != combined_prev);
   endsequence

   property p_hall_trigger;
      @(posedge CLK) disable iff (!RESET_N)
      s_hall_edge |=> CYCLE_START_TRIGGER && CAPTURE_VALID;
   endproperty
   a_hall_trigger: assert property (p_hall_trigger)
      else $error("Hall edge gave no trigger.");

   property p_capture_restart;
      @(posedge CLK) disable iff (!RESET_N)
      s_hall_edge |=> COMMUTATION_PERIOD_CAPTURE == $past(hall_count)
                      && hall_count == `CNT_ZERO;
   endproperty
   a_capture_restart: assert property (p_capture_restart)
      else $error("Capture or restart missing on Hall edge.");

   property p_hall_wrap;
      @(posedge CLK) disable iff (!RESET_N)
      (hall_mode && tick && hall_count == `HALL_CNT_MAX && !hall_edge)
      |=> hall_count == `CNT_ZERO;
   endproperty
   a_hall_wrap: assert property (p_hall_wrap)
      else $error("Hall counter did not wrap at its maximum.");

   property p_sector_levels;
      @(posedge CLK) disable iff (!RESET_N)
      HALL_SECTOR_LEVELS == $past(hall_sync);
   endproperty
   a_sector_levels: assert property (p_sector_levels)
      else $error("Sector levels not the synchronised pins.");

   sequence s_sync_then_trigger;
      PATTERN_SYNC_STROBE ##1 PWM_HW_TRIGGER_TWO;
   endsequence

   property p_sync_apply;
      @(posedge CLK) disable iff (!RESET_N)
      s_sync_then_trigger |=> ACTIVE_SECTOR == $past(NEXT_SECTOR);
   endproperty
   a_sync_apply: assert property (p_sync_apply)
      else $error("Sync strobe did not apply the buffered sector.");

endmodule
`default_nettype wire

/* verilog/sector_pattern_buffer.sv */
// Double-buffered sector pattern applied to the PWM channels on a trigger.
`timescale 1ns/1ps
`default_nettype none
`include "bldc_commutation_params.svh"

module sector_pattern_buffer
   import bldc_commutation_pkg::*;
(
   // Clock and reset.
   input  wire logic                clk,
   input  wire logic                reset_n,
   // Buffered sector and load triggers.
   input  wire sector_e             next_sector,
   input  wire logic                load_one,
   input  wire logic                load_two,
   // Raw and shaped PWM channels.
   input  wire logic [`PWM_CH-1:0]  pwm_raw,
   output var  sector_e             active_sector,
   output var  pattern_s            active_pattern,
   output logic      [`PWM_CH-1:0]  pwm_out
);

   // Looks up the fixed override and mask pair of a sector.
   function automatic pattern_s sector_pattern(input sector_e s);
      pattern_s p;
      p = '{`OVR_OFF, `MSK_OFF};
      unique case (s)
         SECTOR_0:     p = '{`OVR_SECTOR0, `MSK_SECTOR0};
         SECTOR_1:     p = '{`OVR_SECTOR1, `MSK_SECTOR1};
         SECTOR_2:     p = '{`OVR_SECTOR2, `MSK_SECTOR2};
         SECTOR_3:     p = '{`OVR_SECTOR3, `MSK_SECTOR3};
         SECTOR_4:     p = '{`OVR_SECTOR4, `MSK_SECTOR4};
         SECTOR_5:     p = '{`OVR_SECTOR5, `MSK_SECTOR5};
         SECTOR_ALIGN: p = '{`OVR_ALIGN, `MSK_ALIGN};
         SECTOR_OFF:   p = '{`OVR_OFF, `MSK_OFF};
      endcase
      return p;
   endfunction

   // -----------------------------------------------------------------
   // Pattern load
   // -----------------------------------------------------------------

   // Takes the buffered sector on a commutation or a software sync.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_sector  <= SECTOR_OFF;
         active_pattern <= '{`OVR_OFF, `MSK_OFF};
      end else if (load_one || load_two) begin
         active_sector  <= next_sector;
         active_pattern <= sector_pattern(next_sector);
      end
   end

   // Masked channels go inactive, overridden ones take their forced level.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pwm_out <= {`PWM_CH{`MASK_INACTIVE}};
      end else begin
         for (int i = 0; i < `PWM_CH; i++) begin
            if (active_pattern.output_mask_value[i])
               pwm_out[i] <= `MASK_INACTIVE;
            else if (active_pattern.software_output_override[`OVR_EN_LSB + i])
               pwm_out[i] <= active_pattern.software_output_override[`OVR_VAL_LSB + i];
            else
               pwm_out[i] <= pwm_raw[i];
         end
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_pattern_load;
      @(posedge clk) disable iff (!reset_n)
      (load_one || load_two) |=> active_pattern == sector_pattern($past(next_sector));
   endproperty
   a_pattern_load: assert property (p_pattern_load)
      else $error("Pattern not loaded from buffered sector.");

   property p_mask_forces;
      @(posedge clk) disable iff (!reset_n)
      active_pattern.output_mask_value[0] |=> pwm_out[0] == `MASK_INACTIVE;
   endproperty
   a_mask_forces: assert property (p_mask_forces)
      else $error("Masked channel zero not inactive.");

endmodule
`default_nettype wire
